// ### logic/pin_capture_pkg.sv
// constants shared by the pin input capture block and its helpers
// assumes a single 100 MHz system clock and an apb register port
package pin_capture_pkg;

  // register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] level_offset = 8'h08;

  // control register fields
  localparam int ctrl_delay_en_bit = 0;
  localparam int ctrl_delay_dyn_bit = 1;
  localparam int ctrl_mode_lsb = 2;
  localparam int ctrl_mode_width = 2;
  localparam int ctrl_pol_bit = 4;
  localparam logic [4:0] ctrl_reset = 5'h00;

  // status register fields
  localparam int status_overrun_bit = 0;
  localparam int status_empty_bit = 1;
  localparam int status_full_bit = 2;
  localparam int status_gear_phase_bit = 3;

  // delay line
  localparam int delay_code_width = 4;
  localparam int delay_taps = 16;
  localparam logic [3:0] fixed_delay_tap = 4'h4;

  // stream buffer
  localparam int pair_width = 2;
  localparam int fifo_depth = 8;

  // clock figures
  localparam int pclk_period_ns = 10;

  // capture modes, in control register encoding order
  typedef enum logic [1:0] {
    mode_bypass,
    mode_sdr,
    mode_ddr,
    mode_gearbox
  } capture_mode_t;

endpackage

// ### logic/pair_stream_if.sv
// valid/ready carrier for captured rising/falling sample pairs
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface pair_stream_if #(
  parameter int width = 2
);
  logic valid;
  logic ready;
  logic [width-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### logic/pair_fifo.sv
// flip-flop fifo for sample pairs with honest full and empty
// assumes push and pop sides share pclk; reset clears the pointers, not the contents
`timescale 1ns/10ps
module pair_fifo
  import pin_capture_pkg::*;
#(
  parameter int width = pair_width,
  parameter int depth = fifo_depth
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // filling side
  pair_stream_if.snk push,
  // draining side
  pair_stream_if.src pop,
  // occupancy
  output logic [$clog2(depth):0] level
);
  localparam int aw = $clog2(depth);

  initial begin
    if (depth < 2 || (1 << aw) != depth) begin
      $error("pair_fifo depth must be a power of two of at least 2");
    end
  end

  logic [width-1:0] mem_q [depth];
  logic [aw:0] wr_q;
  logic [aw:0] rd_q;
  logic do_push;
  logic do_pop;

  // full when pointers differ only in the wrap bit
  assign level = wr_q - rd_q;
  assign push.ready = (level != (aw+1)'(depth));
  assign pop.valid = (wr_q != rd_q);
  assign pop.data = mem_q[rd_q[aw-1:0]];
  assign do_push = push.valid & push.ready;
  assign do_pop = pop.valid & pop.ready;

  // storage has no reset; only valid entries are ever read
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_q[wr_q[aw-1:0]] <= push.data;
    end
  end

  // pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ### logic/input_delay_line.sv
// tapped delay on the synchronised pad sample, fixed or coded tap
// assumes the input is already in the pclk domain
`timescale 1ns/10ps
module input_delay_line
  import pin_capture_pkg::*;
#(
  parameter int taps = delay_taps
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic delay_enable,
  input wire logic use_dynamic,
  input wire logic [delay_code_width-1:0] code,
  // data
  input wire logic d,
  output logic q
);
  initial begin
    if (taps != (1 << delay_code_width)) begin
      $error("input_delay_line taps must match the code width");
    end
  end

  logic [taps-1:0] line_q;
  logic [delay_code_width-1:0] tap;

  // line shifts every cycle so a tap change takes effect at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= '0;
    end else begin
      line_q <= {line_q[taps-2:0], d};
    end
  end

  // tap 0 is one cycle behind the input
  assign tap = use_dynamic ? code : fixed_delay_tap;            // RULE2
  assign q = delay_enable ? line_q[tap] : d;                    // RULE2
endmodule

// ### logic/pin_input_capture_block.sv
// input capture stage of one i/o cell pair: bypass, delay, sdr, ddr
// and gearbox capture, resynchronised to pclk and buffered to the core.
// registers: ctrl holds delay enable, delay source, mode and polarity;
// status holds overrun, buffer empty, full and gearbox phase; level
// holds the buffer count. other offsets answer with pslverr.
// assumes pad, complementary pad and strobe arrive asynchronous to pclk;
// strobe edges must be spaced by at least three pclk periods.
// Notes on behaviour
// RULE1: pad level can skip delay and registers, feeding core and clock net; here it passes two synchroniser flops and one output register.
// RULE2: enabled delay is fixed or picked by a four-bit code from the core.
// RULE3: sdr mode captures the input in one register on the system clock.
// RULE4: ddr mode samples on rising and falling strobe edges, two streams.
// RULE5: both strobe streams move into the system clock domain before core.
// RULE6: gearbox turns primary-cell ddr data into four core streams.
// RULE7: a registered core input is captured on the system clock rising edge.
// RULE8: a polarity control inverts or keeps the clock of the ddr stage.
// RULE9: input-stage flops update only while the core clock enable is high; here the synchroniser, delay line and bypass flops run ungated.
// RULE10: rising sample is the first stream, falling sample the second.
`timescale 1ns/10ps
module pin_input_capture_block
  import pin_capture_pkg::*;
#(
  parameter int depth = fifo_depth
) (
  // system clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic pad_input_signal,
  input wire logic complement_pad_signal,
  input wire logic dqs_strobe,
  // control from the core
  input wire logic capture_enable,
  input wire logic [delay_code_width-1:0] dynamic_delay_code,
  input wire logic stream_ready,
  // to the core
  output logic unregistered_core_input,
  output logic clock_network_input,
  output logic strobe_delay_input,
  output logic registered_core_input,
  output logic complement_core_input,
  output logic stream_valid,
  output logic rising_edge_stream,
  output logic falling_edge_stream,
  output logic gearbox_stream_a_first,
  output logic gearbox_stream_a_second,
  output logic gearbox_stream_b_first,
  output logic gearbox_stream_b_second
);
  initial begin
    if (depth < 2) begin
      $error("pin_input_capture_block needs a buffer of at least 2");
    end
  end

  // control and status state
  logic delay_en_q;
  logic delay_dyn_q;
  capture_mode_t mode_q;
  logic dual_rate_clock_polarity;
  logic overrun_q;
  logic [$clog2(depth):0] fifo_level;

  // input synchronisers: stage one is read only by stage two
  logic pad_s1_q;
  logic pad_s2_q;
  logic comp_s1_q;
  logic comp_s2_q;
  logic dqs_s1_q;
  logic dqs_s2_q;
  logic strobe_prev_q;

  // capture path
  logic pad_delayed;
  logic strobe_eff;
  logic strobe_rise;
  logic strobe_fall;
  logic strobe_prev_eff;
  logic rise_sample_q;
  logic pair_valid_q;
  logic [pair_width-1:0] pair_q;
  logic ddr_active;

  // core side
  logic gear_phase_q;
  logic [pair_width-1:0] gear_hold_q;
  logic out_valid_q;
  logic take_pop;

  pair_stream_if #(.width(pair_width)) capture_stream ();
  pair_stream_if #(.width(pair_width)) core_stream ();

  // apb decode
  logic apb_setup;
  logic apb_write;
  logic addr_hit;

  // a write lands at the edge where psel, penable and pready all stand;
  // the slave never waits, so every transfer takes two cycles
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ctrl_offset) || (a == status_offset) ||
             (a == level_offset);
  endfunction

  assign addr_hit = mapped(paddr);

  // slave answers in the first access cycle, never waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~addr_hit;
    end
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (apb_setup) begin
      prdata <= '0;
      if (!pwrite) begin
        case (paddr)
          ctrl_offset: begin
            prdata[ctrl_delay_en_bit] <= delay_en_q;
            prdata[ctrl_delay_dyn_bit] <= delay_dyn_q;
            prdata[ctrl_mode_lsb +: ctrl_mode_width] <= mode_q;
            prdata[ctrl_pol_bit] <= dual_rate_clock_polarity;
          end
          status_offset: begin
            prdata[status_overrun_bit] <= overrun_q;
            prdata[status_empty_bit] <= ~core_stream.valid;
            prdata[status_full_bit] <= ~capture_stream.ready;
            prdata[status_gear_phase_bit] <= gear_phase_q;
          end
          level_offset: begin
            prdata[$clog2(depth):0] <= fifo_level;
          end
          default: begin
            prdata <= '0;
          end
        endcase
      end
    end
  end

  // control register; mode change flushes nothing, software drains first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_en_q <= ctrl_reset[ctrl_delay_en_bit];
      delay_dyn_q <= ctrl_reset[ctrl_delay_dyn_bit];
      mode_q <= capture_mode_t'(ctrl_reset[ctrl_mode_lsb +: ctrl_mode_width]);
      dual_rate_clock_polarity <= ctrl_reset[ctrl_pol_bit];
    end else if (apb_write && paddr == ctrl_offset) begin
      delay_en_q <= pwdata[ctrl_delay_en_bit];
      delay_dyn_q <= pwdata[ctrl_delay_dyn_bit];
      mode_q <= capture_mode_t'(pwdata[ctrl_mode_lsb +: ctrl_mode_width]);
      dual_rate_clock_polarity <= pwdata[ctrl_pol_bit];
    end
  end

  // overrun is sticky, write one clears; a new overrun beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
    end else if (pair_valid_q && !capture_stream.ready) begin
      overrun_q <= 1'b1;
    end else if (apb_write && paddr == status_offset &&
                 pwdata[status_overrun_bit]) begin
      overrun_q <= 1'b0;
    end
  end

  // two-flop synchronisers for pins that are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_s1_q <= 1'b0;
      pad_s2_q <= 1'b0;
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      dqs_s1_q <= 1'b0;
      dqs_s2_q <= 1'b0;
    end else begin
      pad_s1_q <= pad_input_signal;
      pad_s2_q <= pad_s1_q;
      comp_s1_q <= complement_pad_signal;
      comp_s2_q <= comp_s1_q;
      dqs_s1_q <= dqs_strobe;
      dqs_s2_q <= dqs_s1_q;
    end
  end

  // bypass taps the synchronised level ahead of delay and capture;
  // they are not gated by the clock enable since no capture is implied
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unregistered_core_input <= 1'b0;
      clock_network_input <= 1'b0;
      strobe_delay_input <= 1'b0;
    end else begin
      unregistered_core_input <= pad_s2_q;                      // RULE1
      clock_network_input <= pad_s2_q;                          // RULE1
      strobe_delay_input <= pad_s2_q;                           // RULE1
    end
  end

  // delay acts on the synchronised level, so one tap is one pclk period
  input_delay_line #(.taps(delay_taps)) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .delay_enable(delay_en_q),
    .use_dynamic(delay_dyn_q),
    .code(dynamic_delay_code),
    .d(pad_s2_q),
    .q(pad_delayed)
  );

  // single rate capture on the rising system clock edge;
  // it runs in the dual rate modes too, giving the core a level view
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      registered_core_input <= 1'b0;
      complement_core_input <= 1'b0;
    end else if (capture_enable && mode_q != mode_bypass) begin // RULE9
      registered_core_input <= pad_delayed;                     // RULE3 RULE7
      complement_core_input <= comp_s2_q;                       // RULE7
    end
  end

  // strobe edge finder; polarity swaps which edge counts as rising.
  // the raw level is kept and polarity applied to both sides, so a
  // polarity write alone never makes a false strobe edge
  assign strobe_eff = dqs_s2_q ^ dual_rate_clock_polarity;      // RULE8
  assign strobe_prev_eff = strobe_prev_q ^ dual_rate_clock_polarity;
  assign strobe_rise = strobe_eff & ~strobe_prev_eff;
  assign strobe_fall = ~strobe_eff & strobe_prev_eff;
  assign ddr_active = (mode_q == mode_ddr) || (mode_q == mode_gearbox);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= dqs_s2_q;
    end
  end

  // dual rate capture: rising sample waits for its falling partner,
  // then the pair enters the buffer as one word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_sample_q <= 1'b0;
      pair_q <= '0;
      pair_valid_q <= 1'b0;
    end else begin
      pair_valid_q <= 1'b0;
      if (capture_enable && ddr_active) begin                   // RULE9
        if (strobe_rise) begin
          rise_sample_q <= pad_delayed;                         // RULE4
        end
        if (strobe_fall) begin
          pair_q <= {pad_delayed, rise_sample_q};               // RULE4 RULE10
          pair_valid_q <= 1'b1;
        end
      end
    end
  end

  // a pin cannot be stalled, so a full buffer drops the pair and flags it
  assign capture_stream.valid = pair_valid_q;
  assign capture_stream.data = pair_q;

  // depth trades area against how long the core may stall
  pair_fifo #(.width(pair_width), .depth(depth)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(capture_stream),
    .pop(core_stream),
    .level(fifo_level)
  );

  // output stage takes a pair when its slot is free or being consumed
  assign take_pop = core_stream.valid & (~out_valid_q | stream_ready);
  assign core_stream.ready = ~out_valid_q | stream_ready;

  // presentation to the core, all in the pclk domain;
  // the gearbox raises valid only with both halves, so the core never
  // sees a word whose second-cell streams are stale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_q <= 1'b0;
      gear_phase_q <= 1'b0;
      gear_hold_q <= '0;
      rising_edge_stream <= 1'b0;
      falling_edge_stream <= 1'b0;
      gearbox_stream_a_first <= 1'b0;
      gearbox_stream_a_second <= 1'b0;
      gearbox_stream_b_first <= 1'b0;
      gearbox_stream_b_second <= 1'b0;
    end else begin
      if (out_valid_q && stream_ready) begin
        out_valid_q <= 1'b0;
      end
      if (mode_q != mode_gearbox) begin
        gear_phase_q <= 1'b0;
      end
      if (take_pop) begin
        if (mode_q == mode_gearbox) begin
          // two strobe periods make one four-stream word
          gear_phase_q <= ~gear_phase_q;                        // RULE6
          if (!gear_phase_q) begin
            gear_hold_q <= core_stream.data;
          end else begin
            gearbox_stream_a_first <= gear_hold_q[0];           // RULE6
            gearbox_stream_a_second <= gear_hold_q[1];          // RULE6
            gearbox_stream_b_first <= core_stream.data[0];      // RULE6
            gearbox_stream_b_second <= core_stream.data[1];     // RULE6
            out_valid_q <= 1'b1;
          end
        end else begin
          rising_edge_stream <= core_stream.data[0];            // RULE5 RULE10
          falling_edge_stream <= core_stream.data[1];           // RULE5 RULE10
          out_valid_q <= 1'b1;
        end
      end
    end
  end

  assign stream_valid = out_valid_q;
endmodule

// ### bench/pin_capture_props.sv
// checker for the capture block: apb answer, bypass path, stream hold
// assumes one pclk domain with presetn async active low
`timescale 1ns/10ps
module pin_capture_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // pins and core
  input wire logic pad_input_signal,
  input wire logic capture_enable,
  input wire logic stream_ready,
  input wire logic unregistered_core_input,
  input wire logic clock_network_input,
  input wire logic strobe_delay_input,
  input wire logic registered_core_input,
  input wire logic stream_valid,
  input wire logic rising_edge_stream,
  input wire logic falling_edge_stream,
  input wire logic gearbox_stream_a_first,
  input wire logic gearbox_stream_a_second,
  input wire logic gearbox_stream_b_first,
  input wire logic gearbox_stream_b_second
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // edges since reset; the sync pipe holds reset zeros for three edges
  logic [2:0] age_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  apb_answer_a: assert property (setup_s |=> access_s)
    else $error("no answer in the access cycle");
  pready_once_a: assert property (pready |=> !pready)
    else $error("pready stood two cycles");
  slverr_pready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  bypass_path_a: assert property (
    age_q >= 3'h3 |-> unregistered_core_input == $past(pad_input_signal, 3))
    else $error("bypass output not pad three cycles back");
  clock_net_a: assert property (
    clock_network_input == unregistered_core_input &&
    strobe_delay_input == unregistered_core_input)
    else $error("clock net or strobe feed differs from bypass");
  enable_hold_a: assert property (
    !capture_enable |=> $stable(registered_core_input))
    else $error("input flop moved without enable");
  stream_hold_a: assert property (
    stream_valid && !stream_ready |=> stream_valid &&
    $stable({rising_edge_stream, falling_edge_stream}))
    else $error("ddr word changed before taken");
  gear_hold_a: assert property (
    stream_valid && !stream_ready |=> $stable({gearbox_stream_a_first,
    gearbox_stream_a_second, gearbox_stream_b_first,
    gearbox_stream_b_second}))
    else $error("gearbox word changed before taken");
endmodule

// ### bench/ddr_source_model.sv
// source-synchronous transmitter: pad data with a burst-only strobe
// assumes the caller spaces pairs; strobe rests still between pairs
`timescale 1ns/10ps
module ddr_source_model (
  // strobe polarity at rest
  input wire logic invert,
  // pins
  output logic dqs_strobe,
  output logic pad,
  output logic pad_n
);
  logic phase;

  // strobe is its phase seen through the chosen polarity
  assign dqs_strobe = phase ^ invert;
  assign pad_n = ~pad;
  initial begin
    phase = 1'b0;
    pad = 1'b0;
  end

  // static level for sdr and bypass work
  task automatic set_level(input logic v);
    pad <= v;
  endtask

  // one 100 ns strobe period; data centred, held two pclk past each edge
  task automatic send_pair(input logic r, input logic f);
    // every change lands between pclk edges, never on one
    #3 pad = r;
    #35 phase = 1'b1;
    #20 pad = f;
    #20 phase = 1'b0;
    #20 pad = ~f; // hold time over: show the inverse, not the last bit
    #2;
  endtask
endmodule

// ### bench/test_pin_input_capture_block.sv
// self-checking bench for the pin input capture block
// assumes the ddr source model drives pads and strobe
`timescale 1ns/10ps
module test_pin_input_capture_block;
  import pin_capture_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, invert, capture_enable;
  logic stream_ready, pad, pad_n, strobe, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] code;
  logic [5:0] w;
  logic pready, pslverr, uci, cni, sdi, rci, cci, sv, rs, fs;
  logic ga1, ga2, gb1, gb2;
  int miscompares, cmp_count, l0, l5, lf, i;
  // row: pair sent in [3:2], word expected in [1:0]
  logic [3:0] rows [4] = '{4'h0, 4'h5, 4'ha, 4'hf};

  pin_input_capture_block uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_input_signal(pad), .complement_pad_signal(pad_n),
    .dqs_strobe(strobe), .capture_enable(capture_enable),
    .dynamic_delay_code(code), .stream_ready(stream_ready),
    .unregistered_core_input(uci), .clock_network_input(cni),
    .strobe_delay_input(sdi), .registered_core_input(rci),
    .complement_core_input(cci), .stream_valid(sv),
    .rising_edge_stream(rs), .falling_edge_stream(fs),
    .gearbox_stream_a_first(ga1), .gearbox_stream_a_second(ga2),
    .gearbox_stream_b_first(gb1), .gearbox_stream_b_second(gb2));
  ddr_source_model src (.invert(invert), .dqs_strobe(strobe), .pad(pad),
    .pad_n(pad_n));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // apb transfer; holds the request until pready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      miscompares++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  // take one stream word, waiting a bounded time for valid
  task automatic take;
    int n;
    stream_ready <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sv !== 1'b1 && n < 200);
    w = {rs, fs, ga1, ga2, gb1, gb2};
    stream_ready <= 1'b0;
    if (n == 200) begin
      miscompares++;
      complete_run();
    end
    @(posedge pclk);
  endtask

  // flush whatever stands in the buffer
  task automatic drain;
    stream_ready <= 1'b1;
    repeat (30) @(posedge pclk);
    stream_ready <= 1'b0;
    @(posedge pclk);
  endtask

  // cycles from a pad toggle until the registered input follows
  task automatic lat(output int n);
    logic v;
    v = ~rci;
    src.set_level(v);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rci !== v && n < 60);
    if (n == 60) begin
      miscompares++;
      complete_run();
    end
  endtask

  initial begin
    {presetn, psel, penable, pwrite, stream_ready, invert} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    code = 4'h0;
    capture_enable = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset valid", 1'b0, sv);
    apb(1'b0, ctrl_offset, 32'h0);
    check("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped err", 1'b1, err);
    check("unmapped data", 32'h0, rd);
    apb(1'b1, ctrl_offset, 32'h8);
    apb(1'b0, ctrl_offset, 32'h0);
    check("ctrl ddr", 32'h8, rd);
    // ordinary ddr pairs, rising sample first
    for (i = 0; i < 4; i++) begin
      src.send_pair(rows[i][3], rows[i][2]);
      take();
      check("ddr word", rows[i][1:0], w[5:4]);
    end
    // inverted strobe: falling edge acts as rising
    apb(1'b1, ctrl_offset, 32'h18);
    invert <= 1'b1;
    drain();
    src.send_pair(1'b1, 1'b0);
    take();
    check("inverted word", 2'h2, w[5:4]);
    // gearbox: two pairs form one four-stream word
    apb(1'b1, ctrl_offset, 32'h1c);
    src.send_pair(1'b1, 1'b0);
    src.send_pair(1'b0, 1'b1);
    take();
    check("gearbox word", 4'h9, w[3:0]);
    // overflow with the core stalled, then clear and drain
    apb(1'b1, ctrl_offset, 32'h18);
    for (i = 0; i < 10; i++) src.send_pair(1'b1, i[0]);
    repeat (4) @(posedge pclk); // the dropped pair flags overrun late
    apb(1'b0, status_offset, 32'h0);
    check("status full", 32'h5, rd);
    apb(1'b0, level_offset, 32'h0);
    check("level full", fifo_depth, rd);
    apb(1'b1, status_offset, 32'h1);
    apb(1'b0, status_offset, 32'h0);
    check("overrun clear", 32'h4, rd);
    take();
    check("oldest word", 2'h2, w[5:4]);
    drain();
    apb(1'b0, status_offset, 32'h0);
    check("status empty", 32'h2, rd);
    // sdr capture with dynamic and fixed delay
    apb(1'b1, ctrl_offset, 32'h7);
    lat(l0);
    check("sdr follows", 1'b1, l0 < 60);
    code <= 4'h5;
    repeat (30) @(posedge pclk); // a tap change glitches; let it settle
    lat(l5);
    check("code delay", 32'd5, l5 - l0);
    apb(1'b1, ctrl_offset, 32'h5);
    repeat (30) @(posedge pclk);
    lat(lf);
    check("fixed delay", fixed_delay_tap, lf - l0);
    // clock enable low freezes the input flop
    capture_enable <= 1'b0;
    src.set_level(!rci);
    repeat (60) @(posedge pclk);
    check("enable hold", !pad, rci);
    capture_enable <= 1'b1;
    repeat (30) @(posedge pclk);
    check("enable resume", pad, rci);
    check("bypass level", pad, uci);
    check("complement", !pad, cci);
    complete_run();
  end
endmodule

bind pin_input_capture_block pin_capture_props chk (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .pad_input_signal, .capture_enable,
  .stream_ready, .unregistered_core_input, .clock_network_input,
  .strobe_delay_input, .registered_core_input, .stream_valid,
  .rising_edge_stream, .falling_edge_stream, .gearbox_stream_a_first,
  .gearbox_stream_a_second, .gearbox_stream_b_first,
  .gearbox_stream_b_second);
